/* hdl/ionrl_top.sv */
// Purpose: Channel register logic: 12 digital channels, counter, one analog input.
// Assumes: Pins and the register port are synchronous to clk_sys_i.
// Notes: Read data appears one cycle after a read request.
`timescale 1ns/10ps
// Operation
// - One shared debounce value in 100 us units; zero disables filtering.
// - Inputs are sampled every 200 us; even settings suit that tick.
// - Debounce settings above 250 saturate to 250, 25 ms.
// - Counter bits 3:0 pick gate time base among nine frequencies.
// - Rising edge of counter bit 5 clears the counter.
// - Bits 7:6 select event or gate mode; 16-bit result reported.
// - Analog bits 2:0 select filter off or levels 2 to 128.
// - Analog bits 6:4 limit ramp step from none to 0x00FF.
// - Below the lower limit, reading holds the limit and underflow flag sets.
// - Above the upper limit, reading holds the limit and overflow flag sets.
// - Underflow in status bit 0, overflow in bit 1, rest reserved.
// - Any analog status change sends an error message.
// - Output commands apply at fixed offset after the sync point.
// - Each output follows its own command bit; 1 sets, 0 resets.
// - Fault bit is one on short circuit or overload, else zero.
// - Rising input edges set sticky capture bits at 200 us resolution.
// - Clear bit at one clears capture and blocks new edges.
// - Filtered inputs 1-8 and 9-12 reported in two registers.
// - Analog reading is a 16-bit value 0 to 32767.
// - Full I/O update every network cycle of 250 us or more.
// - Limit monitoring uses new thresholds as soon as written.
// - A commanded state change clears that output's fault result.
// - Direction bit zero is input, one is output.
module ionrl_top
  import ionrl_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int SYNC_OFFSET = SYNC_OFFSET_CYC
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire ionrl_req_t reg_i,
  output logic [15:0] reg_rdata_o,
  input wire logic sync_point_i,
  input wire logic [NCH-1:0] pin_level_i,
  input wire logic [NCH-1:0] out_actual_i,
  output logic [NCH-1:0] out_drive_o,
  input wire logic adc_valid_i,
  input wire logic [15:0] adc_data_i,
  output logic err_msg_o
);
  logic [7:0] debounce_ff, cnt_setup_ff, smooth_ff;
  logic [15:0] low_thr_ff, high_thr_ff;
  logic [NCH-1:0] dir_ff, cmd_ff, drive_ff, fault_ff, cap_ff, clr_ff;
  logic [NCH-1:0] filt_ff, filt_prev_ff;
  logic [15:0] tick_cnt_ff, sync_cnt_ff, count_ff, gate_cnt_ff;
  logic [23:0] phase_ff;
  logic [22:0] smooth_acc_ff;
  logic [15:0] ramp_ff, reading_ff, rdata_ff;
  logic [1:0] flags_ff;
  logic err_ff, tick, cs_clr_prev_ff, apply;
  logic [6:0] deb_ticks;
  ionrl_sync_t sync_st_ff;

  wire wr_lo = reg_i.wr;
  wire [7:0] wb = reg_i.wdata[7:0];

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      debounce_ff <= CFG_RST;
      cnt_setup_ff <= CFG_RST;
      smooth_ff <= CFG_RST;
      low_thr_ff <= LOW_THR_RST;
      high_thr_ff <= HIGH_THR_RST;
      dir_ff <= '0;
      cmd_ff <= '0;
      clr_ff <= '0;
    end else if (wr_lo) begin
      unique case (reg_i.addr)
        A_DEBOUNCE: debounce_ff <= (wb > FILT_MAX) ? FILT_MAX : wb;
        A_CNT_SETUP: cnt_setup_ff <= wb & 8'hef;
        A_SMOOTH: smooth_ff <= wb & 8'h77;
        A_LOW_THR: low_thr_ff <= {1'b0, reg_i.wdata[14:0]};
        A_HIGH_THR: high_thr_ff <= {1'b0, reg_i.wdata[14:0]};
        A_DIR_LO: dir_ff[7:0] <= wb;
        A_DIR_HI: dir_ff[11:8] <= wb[3:0];
        A_OUT_LO: cmd_ff[7:0] <= wb;
        A_OUT_HI: cmd_ff[11:8] <= wb[3:0];
        A_CLR_LO: clr_ff[7:0] <= wb;
        A_CLR_HI: clr_ff[11:8] <= wb[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i || tick) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 16'h0001;
    end
  end
  assign tick = (tick_cnt_ff == 16'(TICK_CYCLES - 1));

  // Debounce time in ticks, rounded up; even settings match the tick exactly.
  assign deb_ticks = 7'((debounce_ff + 8'h01) >> 1);

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [6:0] stab_ff;
    always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
        stab_ff <= '0;
        filt_ff[c] <= 1'b0;
      end else if (tick) begin
        if (dir_ff[c] || pin_level_i[c] == filt_ff[c]) begin
          stab_ff <= '0;
        end else if (debounce_ff == 8'h00 || stab_ff + 7'h01 >= deb_ticks) begin
          stab_ff <= '0;
          filt_ff[c] <= pin_level_i[c];
        end else begin
          stab_ff <= stab_ff + 7'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cap_ff <= '0;
      filt_prev_ff <= '0;
    end else begin
      if (tick) begin
        filt_prev_ff <= filt_ff;
      end
      cap_ff <= (cap_ff | ({NCH{tick}} & filt_ff & ~filt_prev_ff)) & ~clr_ff;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      sync_st_ff <= ST_IDLE;
      sync_cnt_ff <= '0;
    end else begin
      unique case (sync_st_ff)
        ST_IDLE: if (sync_point_i) begin
          sync_st_ff <= ST_WAIT;
          sync_cnt_ff <= '0;
        end
        ST_WAIT: begin
          sync_cnt_ff <= sync_cnt_ff + 16'h0001;
          if (apply) begin
            sync_st_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end
  assign apply = (sync_st_ff == ST_WAIT) && (sync_cnt_ff == 16'(SYNC_OFFSET - 1));

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      drive_ff <= '0;
    end else if (apply) begin
      drive_ff <= cmd_ff;
    end
  end
  assign out_drive_o = drive_ff & dir_ff;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      fault_ff <= '0;
    end else if (apply) begin
      // Only channels whose command changes lose their monitoring result.
      fault_ff <= fault_ff & ~(drive_ff ^ cmd_ff);
    end else begin
      fault_ff <= dir_ff & (out_actual_i ^ drive_ff);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      count_ff <= '0;
      gate_cnt_ff <= '0;
      phase_ff <= '0;
      cs_clr_prev_ff <= 1'b0;
    end else begin
      cs_clr_prev_ff <= cnt_setup_ff[CS_CLR_BIT];
      if (cnt_setup_ff[CS_CLR_BIT] && !cs_clr_prev_ff) begin
        count_ff <= '0;
        gate_cnt_ff <= '0;
      end else if (cnt_setup_ff[CS_MODE_POS +: 2] == MODE_GATE) begin
        phase_ff <= phase_ff + ((cnt_setup_ff[3:0] <= 4'h8) ? TB_INC[cnt_setup_ff[3:0]] : 24'h0);
        if (filt_ff[1]) begin
          // Count rising MSB edges only, one per time-base period.
          gate_cnt_ff <= gate_cnt_ff + 16'(!phase_ff[23] && phase_next_msb());
        end else if (filt_prev_ff[1] && tick) begin
          count_ff <= gate_cnt_ff;
          gate_cnt_ff <= '0;
        end
      end else if (tick && filt_ff[0] && !filt_prev_ff[0]) begin
        count_ff <= count_ff + 16'h0001;
      end
    end
  end

  function automatic logic phase_next_msb();
    logic [23:0] p;
    p = phase_ff + ((cnt_setup_ff[3:0] <= 4'h8) ? TB_INC[cnt_setup_ff[3:0]] : 24'h0);
    return p[23];
  endfunction

  logic [22:0] acc_next;
  logic signed [16:0] step;
  logic [15:0] lim, ramp_next, x_in;
  always_comb begin
    x_in = adc_data_i[15] ? 16'h0000 : adc_data_i;
    if (smooth_ff[2:0] == 3'h0) begin
      acc_next = {x_in, 7'h00};
    end else begin
      acc_next = 23'(smooth_acc_ff + 23'($signed({1'b0, x_in, 7'h00} - {1'b0, smooth_acc_ff})
        >>> smooth_ff[2:0]));
    end
    lim = RAMP_LIM[smooth_ff[6:4]];
    step = $signed({1'b0, acc_next[22:7]}) - $signed({1'b0, ramp_ff});
    if (step > $signed({1'b0, lim})) begin
      ramp_next = ramp_ff + lim;
    end else if (step < -$signed({1'b0, lim})) begin
      ramp_next = ramp_ff - lim;
    end else begin
      ramp_next = acc_next[22:7];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      smooth_acc_ff <= '0;
      ramp_ff <= '0;
    end else if (adc_valid_i) begin
      smooth_acc_ff <= acc_next;
      ramp_ff <= ramp_next;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      reading_ff <= '0;
      flags_ff <= '0;
    end else if (ramp_ff < low_thr_ff) begin
      reading_ff <= low_thr_ff;
      flags_ff <= 2'b01;
    end else if (ramp_ff > high_thr_ff) begin
      reading_ff <= high_thr_ff;
      flags_ff <= 2'b10;
    end else begin
      reading_ff <= ramp_ff;
      flags_ff <= 2'b00;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      err_ff <= 1'b0;
    end else begin
      err_ff <= (ramp_ff < low_thr_ff) != flags_ff[0] || (ramp_ff > high_thr_ff
        && !(ramp_ff < low_thr_ff)) != flags_ff[1];
    end
  end
  assign err_msg_o = err_ff;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rdata_ff <= '0;
    end else if (reg_i.rd) begin
      unique case (reg_i.addr)
        A_IN_LO: rdata_ff <= {8'h00, filt_ff[7:0]};
        A_IN_HI: rdata_ff <= {12'h000, filt_ff[11:8]};
        A_OUT_LO: rdata_ff <= {8'h00, cmd_ff[7:0]};
        A_OUT_HI: rdata_ff <= {12'h000, cmd_ff[11:8]};
        A_COUNT: rdata_ff <= count_ff;
        A_ANALOG: rdata_ff <= reading_ff;
        A_LOW_THR: rdata_ff <= low_thr_ff;
        A_HIGH_THR: rdata_ff <= high_thr_ff;
        A_DIR_LO: rdata_ff <= {8'h00, dir_ff[7:0]};
        A_DIR_HI: rdata_ff <= {12'h000, dir_ff[11:8]};
        A_DEBOUNCE: rdata_ff <= {8'h00, debounce_ff};
        A_CNT_SETUP: rdata_ff <= {8'h00, cnt_setup_ff};
        A_SMOOTH: rdata_ff <= {8'h00, smooth_ff};
        A_FLAGS: rdata_ff <= {14'h0000, flags_ff};
        A_CAP_LO: rdata_ff <= {8'h00, cap_ff[7:0]};
        A_CAP_HI: rdata_ff <= {12'h000, cap_ff[11:8]};
        A_FAULT_LO: rdata_ff <= {8'h00, fault_ff[7:0]};
        A_FAULT_HI: rdata_ff <= {12'h000, fault_ff[11:8]};
        default: rdata_ff <= '0;
      endcase
    end
  end
  assign reg_rdata_o = rdata_ff;

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  filter_saturate_a: assert property (debounce_ff <= FILT_MAX)
    else $error("debounce setting above saturation");
  capture_clear_a: assert property (|clr_ff |=> ((cap_ff & $past(clr_ff)) == '0))
    else $error("capture bit set while clear held");
  counter_clear_a: assert property ($rose(cnt_setup_ff[CS_CLR_BIT]) |=> count_ff == 16'h0000)
    else $error("counter not cleared on setup bit rise");
  below_hold_a: assert property (flags_ff[0] && $stable(low_thr_ff)
    |-> reading_ff == low_thr_ff)
    else $error("underflow without holding lower limit");
  above_hold_a: assert property (flags_ff[1] && $stable(high_thr_ff)
    |-> reading_ff == high_thr_ff)
    else $error("overflow without holding upper limit");
  error_message_a: assert property (flags_ff != $past(flags_ff) |-> err_msg_o)
    else $error("flag change without error message");
  sync_apply_a: assert property (apply |=> drive_ff == $past(cmd_ff))
    else $error("command not applied at sync offset");
  fault_reset_a: assert property (apply
    |=> (fault_ff & ($past(drive_ff) ^ $past(cmd_ff))) == '0)
    else $error("fault not cleared on command update");
  output_nofilter_a: assert property (
    ((filt_ff ^ $past(filt_ff)) & dir_ff & $past(dir_ff)) == '0)
    else $error("output channel level filtered");
  reading_range_a: assert property (reading_ff[15] == 1'b0)
    else $error("analog reading out of range");
  cap_seen_c: cover property (|cap_ff);
  apply_seen_c: cover property (apply);
  under_seen_c: cover property ($rose(flags_ff[0]));
endmodule

/* hdl/ionrl_pkg.sv */
// Purpose: Shared constants and types for the I/O node channel register logic.
// Assumes: 100 MHz system clock, 16-bit register port addressed by register number.
// Notes: Register numbers are byte offsets; 16-bit registers occupy two numbers.
package ionrl_pkg;
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 200;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int FILT_UNIT_US = 100;
  localparam int SYNC_OFFSET_CYC = 1000;
  localparam int NCH = 12;
  localparam logic [7:0] FILT_MAX = 8'hfa;

  localparam logic [4:0] A_IN_LO = 5'h00;
  localparam logic [4:0] A_IN_HI = 5'h01;
  localparam logic [4:0] A_OUT_LO = 5'h02;
  localparam logic [4:0] A_OUT_HI = 5'h03;
  localparam logic [4:0] A_COUNT = 5'h04;
  localparam logic [4:0] A_ANALOG = 5'h06;
  localparam logic [4:0] A_LOW_THR = 5'h0a;
  localparam logic [4:0] A_HIGH_THR = 5'h0c;
  localparam logic [4:0] A_DIR_LO = 5'h10;
  localparam logic [4:0] A_DIR_HI = 5'h11;
  localparam logic [4:0] A_DEBOUNCE = 5'h12;
  localparam logic [4:0] A_CNT_SETUP = 5'h14;
  localparam logic [4:0] A_SMOOTH = 5'h16;
  localparam logic [4:0] A_FLAGS = 5'h18;
  localparam logic [4:0] A_CAP_LO = 5'h1a;
  localparam logic [4:0] A_CAP_HI = 5'h1b;
  localparam logic [4:0] A_CLR_LO = 5'h1c;
  localparam logic [4:0] A_CLR_HI = 5'h1d;
  localparam logic [4:0] A_FAULT_LO = 5'h1e;
  localparam logic [4:0] A_FAULT_HI = 5'h1f;

  localparam int CS_CLR_BIT = 5;
  localparam int CS_MODE_POS = 6;
  localparam logic [1:0] MODE_GATE = 2'h1;
  localparam logic [15:0] LOW_THR_RST = 16'h0000;
  localparam logic [15:0] HIGH_THR_RST = 16'h7fff;
  localparam logic [7:0] CFG_RST = 8'h00;

  // Phase increments of a 24-bit accumulator at 100 MHz for each time base.
  localparam logic [23:0] TB_INC [9] = '{24'h7ae148, 24'h07ae14, 24'h007ae1, 24'h3d70a4,
    24'h1eb852, 24'h0f5c29, 24'h03d70a, 24'h01eb85, 24'h00f5c3};
  localparam logic [15:0] RAMP_LIM [8] = '{16'hffff, 16'h3fff, 16'h1fff, 16'h0fff,
    16'h07ff, 16'h03ff, 16'h01ff, 16'h00ff};

  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } ionrl_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } ionrl_sync_t;
endpackage

/* verification/ionrl_ctrl_model.sv */
// Purpose: Network controller model for the register port and sync point.
// Assumes: Requests change on the falling clock edge.
// Notes: Released address and data lines show the inverse of the last value.
`timescale 1ns/10ps
module ionrl_ctrl_model
  import ionrl_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic [15:0] rdata_i,
  output ionrl_req_t reg_o,
  output logic sync_o
);
  initial begin
    reg_o = '0;
    sync_o = 1'b0;
  end

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_sys_i);
    reg_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_sys_i);
    reg_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge clk_sys_i);
    reg_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge clk_sys_i);
    reg_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hffff};
    d = rdata_i;
  endtask

  task automatic clear_capture(input logic [7:0] m);
    wr(A_CLR_LO, {8'h00, m});
  endtask

  task automatic sync_pulse();
    @(negedge clk_sys_i);
    sync_o = 1'b1;
    @(negedge clk_sys_i);
    sync_o = 1'b0;
  endtask
endmodule

/* verification/test_ionrl_top.sv */
// Purpose: Self-checking bench for the channel register logic.
// Assumes: Short tick and sync offset parameters.
// Notes: Register rows first, then hand-written cases.
`timescale 1ns/10ps
module test_ionrl_top
  import ionrl_pkg::*;
;
  localparam int TK = 20;
  localparam int SO = 5;
  typedef struct {
    logic [4:0] a;
    logic [15:0] d;
    logic [15:0] e;
  } ionrl_row_t;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  ionrl_req_t reg_i;
  logic [15:0] rdata;
  logic sync;
  logic [NCH-1:0] pin = '0;
  logic [NCH-1:0] inj = '0;
  logic [NCH-1:0] drive;
  logic adc_valid = 1'b0;
  logic [15:0] adc_data = 16'h0000;
  logic err;
  logic [15:0] err_cnt = 16'h0000;
  int failures = 0;
  int check_count = 0;
  ionrl_row_t rows [9] = '{
    '{A_DEBOUNCE, 16'h0004, 16'h0004},
    '{A_CNT_SETUP, 16'h00ff, 16'h00ef},
    '{A_SMOOTH, 16'h00ff, 16'h0077},
    '{A_LOW_THR, 16'h1234, 16'h1234},
    '{A_HIGH_THR, 16'h7000, 16'h7000},
    '{A_DIR_HI, 16'h00ff, 16'h000f},
    '{A_OUT_HI, 16'h00ff, 16'h000f},
    '{5'h08, 16'hffff, 16'h0000},
    '{A_FLAGS, 16'h0003, 16'h0001}};

  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      err_cnt <= 16'h0000;
    end else if (err === 1'b1) begin
      err_cnt <= err_cnt + 16'h0001;
    end
  end

  ionrl_top #(.TICK_CYCLES(TK), .SYNC_OFFSET(SO)) DUT (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .reg_i(reg_i),
    .reg_rdata_o(rdata),
    .sync_point_i(sync),
    .pin_level_i(pin),
    .out_actual_i(drive ^ inj),
    .out_drive_o(drive),
    .adc_valid_i(adc_valid),
    .adc_data_i(adc_data),
    .err_msg_o(err)
  );

  ionrl_ctrl_model ctrl (
    .clk_sys_i(clk_sys_i),
    .rdata_i(rdata),
    .reg_o(reg_i),
    .sync_o(sync)
  );

  task automatic stop_test();
    if (failures == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_range(input logic [15:0] got, input logic [15:0] lo,
    input logic [15:0] hi);
    check_count++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    ctrl.rd(a, d);
    check16(d, exp);
  endtask

  task automatic ticks(input int n);
    repeat (n * TK) @(negedge clk_sys_i);
  endtask

  task automatic adc(input logic [15:0] v);
    @(negedge clk_sys_i);
    adc_valid = 1'b1;
    adc_data = v;
    @(negedge clk_sys_i);
    adc_valid = 1'b0;
    adc_data = ~v;
    repeat (3) @(negedge clk_sys_i);
  endtask

  task automatic do_reset();
    reset_i = 1'b1;
    repeat (6) @(negedge clk_sys_i);
    reset_i = 1'b0;
  endtask

  initial begin
    logic [15:0] av [3] = '{16'h0032, 16'h01f4, 16'h07d0};
    logic [15:0] ar [3] = '{16'h0064, 16'h01f4, 16'h03e8};
    logic [15:0] af [3] = '{16'h0001, 16'h0000, 16'h0002};
    logic [15:0] gd;
    do_reset();
    foreach (rows[i]) begin
      ctrl.wr(rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].e);
    end
    do_reset();
    rdchk(A_HIGH_THR, 16'h7fff);
    rdchk(A_CNT_SETUP, 16'h0000);
    rdchk(A_DIR_HI, 16'h0000);
    check16({4'h0, drive}, 16'h0000);
    ctrl.wr(A_DIR_LO, 16'h00ff);
    ctrl.wr(A_DIR_HI, 16'h000f);
    ctrl.wr(A_OUT_LO, 16'h00a5);
    ctrl.wr(A_OUT_HI, 16'h000a);
    ctrl.sync_pulse();
    repeat (SO - 1) @(negedge clk_sys_i);
    check16({4'h0, drive}, 16'h0000);
    repeat (2) @(negedge clk_sys_i);
    check16({4'h0, drive}, 16'h0aa5);
    inj = 12'h001;
    repeat (3) @(negedge clk_sys_i);
    rdchk(A_FAULT_LO, 16'h0001);
    // The fault stays injected; the read is taken on the edge after the apply.
    ctrl.wr(A_OUT_LO, 16'h00a4);
    ctrl.sync_pulse();
    repeat (SO - 1) @(negedge clk_sys_i);
    rdchk(A_FAULT_LO, 16'h0000);
    rdchk(A_FAULT_LO, 16'h0001);
    inj = 12'h000;
    ctrl.wr(A_DIR_LO, 16'h0000);
    ctrl.wr(A_DIR_HI, 16'h0000);
    pin = 12'h801;
    ticks(3);
    rdchk(A_IN_LO, 16'h0001);
    rdchk(A_IN_HI, 16'h0008);
    rdchk(A_CAP_HI, 16'h0008);
    ctrl.clear_capture(8'h01);
    pin = 12'h000;
    ticks(2);
    pin = 12'h001;
    ticks(2);
    rdchk(A_CAP_LO, 16'h0000);
    pin = 12'h000;
    ctrl.wr(A_CNT_SETUP, 16'h0020);
    ctrl.wr(A_CNT_SETUP, 16'h0000);
    ticks(2);
    rdchk(A_COUNT, 16'h0000);
    repeat (3) begin
      pin = 12'h001;
      ticks(2);
      pin = 12'h000;
      ticks(2);
    end
    rdchk(A_COUNT, 16'h0003);
    ctrl.wr(A_CNT_SETUP, 16'h0020);
    rdchk(A_COUNT, 16'h0000);
    // Gate mode at the fastest base: 40 cycles of gate give 19.2 counts.
    ctrl.wr(A_CNT_SETUP, 16'h0040);
    pin = 12'h002;
    ticks(2);
    pin = 12'h000;
    ticks(3);
    ctrl.rd(A_COUNT, gd);
    check_range(gd, 16'h0013, 16'h0014);
    ctrl.wr(A_DEBOUNCE, 16'h0008);
    pin = 12'h002;
    ticks(2);
    rdchk(A_IN_LO, 16'h0000);
    ticks(4);
    rdchk(A_IN_LO, 16'h0002);
    ctrl.wr(A_DEBOUNCE, 16'h00ff);
    pin = 12'h004;
    ticks(100);
    rdchk(A_IN_LO, 16'h0002);
    ticks(27);
    rdchk(A_IN_LO, 16'h0004);
    ctrl.wr(A_LOW_THR, 16'h0064);
    ctrl.wr(A_HIGH_THR, 16'h03e8);
    for (int i = 0; i < 3; i++) begin
      adc(av[i]);
      rdchk(A_ANALOG, ar[i]);
      rdchk(A_FLAGS, af[i]);
      check16(err_cnt, 16'(i + 1));
    end
    ctrl.wr(A_LOW_THR, 16'h0000);
    ctrl.wr(A_HIGH_THR, 16'h7fff);
    ctrl.wr(A_SMOOTH, 16'h0070);
    adc(16'h0000);
    rdchk(A_ANALOG, 16'h06d1);
    ctrl.wr(A_SMOOTH, 16'h0001);
    adc(16'h03e8);
    rdchk(A_ANALOG, 16'h01f4);
    stop_test();
  end

  initial begin
    repeat (40000) @(posedge clk_sys_i);
    failures++;
    stop_test();
  end
endmodule
